// >>> wdt_pkg.sv
// package for the watchdog timer block: constants, types
// assumes core_clk at 50 MHz and a 32 kHz tick source sampled on it
`default_nettype none
package wdt_pkg;
  // clock and time figures
  localparam int unsigned core_clk_hz = 50000000;
  localparam int unsigned rc_osc_hz = 32000;
  // prescaler lengths (5-bit and 7-bit)
  localparam int unsigned pre_short_div = 32;
  localparam int unsigned pre_long_div = 128;
  localparam logic [6:0] pre_short_last = 7'h1f;
  localparam logic [6:0] pre_long_last = 7'h7f;
  // postscaler field width and count width
  localparam int unsigned post_sel_w = 4;
  localparam int unsigned post_cnt_w = 15;
  // reset values
  localparam logic [6:0] pre_reset = 7'h00;
  localparam logic [14:0] post_reset = 15'h0000;
  // window mode: final quarter of the period
  localparam int unsigned window_shift = 2;

  typedef enum logic [1:0]
  {
    wdt_off = 2'b00,
    wdt_run = 2'b01,
    wdt_fire = 2'b11
  } wdt_state_type;

  // configuration word fields
  typedef struct packed
  {
    logic config_watchdog_enable;
    logic window_disable;
    logic prescale_select;
    logic [3:0] postscale_select;
  } wdt_config_type;

  // clearing events from the core
  typedef struct packed
  {
    logic watchdog_clear_instr;
    logic power_save_instr;
    logic power_save_exit;
    logic clock_switch_done;
  } wdt_clear_type;
endpackage : wdt_pkg
`default_nettype wire

// >>> wdt_tick_sync.sv
// two-stage synchroniser plus rising-edge detector for the rc clock
// assumes the rc clock is much slower than core_clk
`timescale 1ns/10ps
`default_nettype none
module wdt_tick_sync
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // async rc oscillator clock in, tick out
  input wire logic async_clk,
  output logic tick
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic tick_q;
  logic tick_d;

  always_comb
  begin
    sync_d = {sync_q[1:0], async_clk};
    // only stages 1 and 2 feed the edge detector
    tick_d = sync_q[1] & ~sync_q[2];
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // all ones: no false tick if the rc clock is high at release
      sync_q <= 3'h7;
      tick_q <= 1'b0;
    end
    else
    begin
      sync_q <= sync_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : wdt_tick_sync
`default_nettype wire

// >>> wdt_core.sv
// watchdog timer: prescaler, postscaler, window check, time-out actions
// assumes the rc oscillator arrives on low_power_rc_osc and core events
// are one-cycle pulses on core_clk
`timescale 1ns/10ps
`default_nettype none
// Function
// - counts rc oscillator; enable powers it
// - prescaler divides 32 or 128
// - prescale period about 1 or 4 ms
// - four-bit postscaler, sixteen ratio settings
// - resets, power-save, exit, clear zero counters
// - completed clock switch zeroes counters
// - keeps counting during sleep and idle
// - time-out in sleep wakes, no reset
// - config enable forces watchdog on
// - time-out flag sticky until software clears
// - config off: soft enable bit controls
// - soft enable cleared by reset_n, kept on time-out reset
// - early clear in window mode resets
// - wake and reset keep sleep flag
module wdt_core
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // rc oscillator
  input wire logic low_power_rc_osc,
  output logic low_power_rc_osc_enable,
  // configuration word
  input wire wdt_pkg::wdt_config_type watchdog_config_word,
  // software enable bit
  input wire logic soft_enable_set,
  input wire logic soft_enable_clear,
  output logic soft_watchdog_enable,
  // core events
  input wire wdt_pkg::wdt_clear_type clear_events,
  input wire logic in_power_save,
  // status flags
  input wire logic timeout_flag_clear,
  input wire logic sleep_flag_clear,
  output logic timeout_flag,
  output logic sleep_flag,
  // actions
  output logic watchdog_reset,
  output logic watchdog_wake
);
  logic tick;
  logic enabled;
  logic clear_all;
  logic pre_done;
  logic post_done;
  logic early_clear;
  logic [6:0] pre_last;
  logic [14:0] post_last;
  logic [14:0] window_start;
  logic [6:0] pre_q;
  logic [6:0] pre_d;
  logic [14:0] post_q;
  logic [14:0] post_d;
  logic soft_en_q;
  logic soft_en_d;
  logic to_flag_q;
  logic to_flag_d;
  logic sleep_q;
  logic sleep_d;
  logic rst_q;
  logic rst_d;
  logic wake_q;
  logic wake_d;
  logic osc_en_q;
  logic osc_en_d;
  wdt_pkg::wdt_state_type state_q;
  wdt_pkg::wdt_state_type state_d;

  // rc clock sampled as count source
  wdt_tick_sync u_sync
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_clk(low_power_rc_osc),
    .tick(tick)
  );

  always_comb
  begin
    enabled = watchdog_config_word.config_watchdog_enable | soft_en_q;
    pre_last = watchdog_config_word.prescale_select ? wdt_pkg::pre_long_last : wdt_pkg::pre_short_last;
    post_last = 15'((32'h1 << watchdog_config_word.postscale_select) - 32'h1);
    window_start = post_last - 15'(post_last >> wdt_pkg::window_shift);
    early_clear = clear_events.watchdog_clear_instr & enabled & ~in_power_save
      & ~watchdog_config_word.window_disable & (post_q < window_start);
    clear_all = clear_events.watchdog_clear_instr | clear_events.power_save_instr
      | clear_events.power_save_exit | clear_events.clock_switch_done | ~enabled;
    pre_done = tick & (pre_q == pre_last);
    post_done = pre_done & (post_q == post_last);
  end

  // counters
  always_comb
  begin
    pre_d = pre_q;
    post_d = post_q;
    if (clear_all)
    begin
      pre_d = wdt_pkg::pre_reset;
      post_d = wdt_pkg::post_reset;
    end
    // counts regardless of sleep or idle
    else if (tick)
    begin
      if (pre_done)
      begin
        pre_d = wdt_pkg::pre_reset;
        post_d = post_done ? wdt_pkg::post_reset : post_q + 15'h0001;
      end
      else
      begin
        pre_d = pre_q + 7'h01;
      end
    end
  end

  // control state, flags and actions
  always_comb
  begin
    state_d = state_q;
    rst_d = 1'b0;
    wake_d = 1'b0;
    // soft enable held only by the core
    soft_en_d = soft_en_q;
    if (soft_enable_set)
      soft_en_d = 1'b1;
    else if (soft_enable_clear)
      soft_en_d = 1'b0;
    osc_en_d = enabled;
    // sticky flag, set wins over clear
    to_flag_d = to_flag_q & ~timeout_flag_clear;
    sleep_d = sleep_q & ~sleep_flag_clear;
    if (clear_events.power_save_instr)
      sleep_d = 1'b1;
    case (state_q)
      wdt_pkg::wdt_off:
      begin
        if (enabled)
          state_d = wdt_pkg::wdt_run;
      end
      wdt_pkg::wdt_run:
      begin
        if (!enabled)
          state_d = wdt_pkg::wdt_off;
        else if ((post_done && !clear_all) || early_clear)
          state_d = wdt_pkg::wdt_fire;
      end
      wdt_pkg::wdt_fire:
      begin
        state_d = enabled ? wdt_pkg::wdt_run : wdt_pkg::wdt_off;
        to_flag_d = 1'b1;
        if (in_power_save && !early_clear)
          wake_d = 1'b1;
        else
          rst_d = 1'b1;
      end
      default:
      begin
        state_d = wdt_pkg::wdt_off;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_q <= wdt_pkg::pre_reset;
      post_q <= wdt_pkg::post_reset;
      state_q <= wdt_pkg::wdt_off;
      soft_en_q <= 1'b0;
      to_flag_q <= 1'b0;
      sleep_q <= 1'b0;
      rst_q <= 1'b0;
      wake_q <= 1'b0;
      osc_en_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      post_q <= post_d;
      state_q <= state_d;
      soft_en_q <= soft_en_d;
      to_flag_q <= to_flag_d;
      sleep_q <= sleep_d;
      rst_q <= rst_d;
      wake_q <= wake_d;
      osc_en_q <= osc_en_d;
    end
  end

  assign low_power_rc_osc_enable = osc_en_q;
  assign soft_watchdog_enable = soft_en_q;
  assign timeout_flag = to_flag_q;
  assign sleep_flag = sleep_q;
  assign watchdog_reset = rst_q;
  assign watchdog_wake = wake_q;
endmodule : wdt_core
`default_nettype wire

// >>> wdt_core_chk.sv
// assertions on the wdt_core ports
// assumes wdt_pkg is compiled first
`timescale 1ns/10ps
`default_nettype none
module wdt_core_chk
(
  // clock, reset
  input wire logic core_clk,
  input wire logic reset_n,
  // controls
  input wire wdt_pkg::wdt_config_type watchdog_config_word,
  input wire logic in_power_save,
  input wire logic timeout_flag_clear,
  // outputs
  input wire logic low_power_rc_osc_enable,
  input wire logic soft_watchdog_enable,
  input wire logic timeout_flag,
  input wire logic watchdog_reset,
  input wire logic watchdog_wake
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire logic en = watchdog_config_word.config_watchdog_enable || soft_watchdog_enable;
  a_reset_one_cycle: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("reset pulse too long");
  a_wake_one_cycle: assert property (watchdog_wake |=> !watchdog_wake)
    else $error("wake pulse too long");
  a_wake_in_sleep: assert property (watchdog_wake |-> $past(in_power_save) && !watchdog_reset)
    else $error("wake outside sleep");
  a_reset_when_awake: assert property (watchdog_reset |-> !$past(in_power_save))
    else $error("reset during sleep");
  a_flag_on_fire: assert property (watchdog_reset || watchdog_wake |-> timeout_flag)
    else $error("flag not set on time-out");
  a_flag_sticky: assert property (timeout_flag && !timeout_flag_clear |=> timeout_flag)
    else $error("flag dropped");
  a_idle_quiet: assert property (!en [*3] |=> !watchdog_reset && !watchdog_wake)
    else $error("fired while disabled");
  a_osc_follows: assert property ($past(reset_n) && $past(en) |-> low_power_rc_osc_enable)
    else $error("oscillator not enabled");
  c_reset: cover property (watchdog_reset);
  c_wake: cover property (watchdog_wake);
  c_flag_clear: cover property (timeout_flag && timeout_flag_clear);
endmodule : wdt_core_chk
bind wdt_core wdt_core_chk i_chk (.core_clk(core_clk), .reset_n(reset_n),
  .watchdog_config_word(watchdog_config_word), .in_power_save(in_power_save),
  .timeout_flag_clear(timeout_flag_clear), .low_power_rc_osc_enable(low_power_rc_osc_enable),
  .soft_watchdog_enable(soft_watchdog_enable), .timeout_flag(timeout_flag),
  .watchdog_reset(watchdog_reset), .watchdog_wake(watchdog_wake));
`default_nettype wire

// >>> testbench.sv
// self-checking bench for wdt_core
// assumes wdt_pkg, wdt_tick_sync and wdt_core compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic rc = 1'b0;
  logic sw_set = 1'b0;
  logic sw_clr = 1'b0;
  logic in_ps = 1'b0;
  logic to_clr = 1'b0;
  logic sl_clr = 1'b0;
  wdt_pkg::wdt_config_type cfg = '0;
  wdt_pkg::wdt_clear_type ev = '0;
  logic osc_en, sw_en, to_flag, sl_flag, wd_rst, wd_wake;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  always #10 core_clk = ~core_clk;
  // rc clock, 8.3 core cycles a tick
  always #83 rc = ~rc;
  wdt_core i_wdt_core (.core_clk(core_clk), .reset_n(reset_n), .low_power_rc_osc(rc),
    .low_power_rc_osc_enable(osc_en), .watchdog_config_word(cfg), .soft_enable_set(sw_set),
    .soft_enable_clear(sw_clr), .soft_watchdog_enable(sw_en), .clear_events(ev),
    .in_power_save(in_ps), .timeout_flag_clear(to_clr), .sleep_flag_clear(sl_clr),
    .timeout_flag(to_flag), .sleep_flag(sl_flag), .watchdog_reset(wd_rst), .watchdog_wake(wd_wake));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #2;
  endtask : step
  task automatic go(input logic [6:0] c);
    cfg = c;
    reset_n = 1'b0;
    step(3);
    reset_n = 1'b1;
    step(1);
    chk("after reset", 16'({to_flag, sl_flag, sw_en, wd_rst}), 16'h0);
  endtask : go
  task automatic pulse(input logic [3:0] e);
    ev = e;
    step(1);
    ev = '0;
  endtask : pulse
  task automatic fire(input int lim);
    n = 0;
    while (wd_rst !== 1'b1 && wd_wake !== 1'b1 && n < lim)
    begin
      step(1);
      n++;
    end
  endtask : fire
  // expects a time-out after about tk rc ticks
  task automatic fire_at(input string what, input int tk);
    fire(tk * 9 + 30);
    chk(what, 16'(n >= tk * 83 / 10 - 12 && n <= tk * 83 / 10 + 20), 16'h1);
  endtask : fire_at
  task automatic t_soft;
    go(7'h20);
    fire(600);
    chk("disabled", 16'(n), 16'd600);
    chk("osc off", 16'(osc_en), 16'h0);
    sw_set = 1'b1;
    step(1);
    sw_set = 1'b0;
    chk("soft bit", 16'(sw_en), 16'h1);
    fire_at("soft enable", 32);
    chk("timeout", 16'({wd_rst, to_flag, osc_en}), 16'h7);
    step(4);
    chk("sticky", 16'(to_flag), 16'h1);
    to_clr = 1'b1;
    step(1);
    to_clr = 1'b0;
    chk("flag clear", 16'(to_flag), 16'h0);
    sw_clr = 1'b1;
    step(1);
    sw_clr = 1'b0;
    fire(600);
    chk("soft off", 16'(n), 16'd600);
    chk("soft bit off", 16'({sw_en, osc_en}), 16'h0);
    $display("soft test done");
  endtask : t_soft
  task automatic t_scale;
    logic [4:0] ps [4] = '{5'h00, 5'h10, 5'h02, 5'h11};
    foreach (ps[i])
    begin
      go({2'b11, ps[i]});
      fire_at("scale", (ps[i][4] ? 128 : 32) << ps[i][3:0]);
    end
    $display("scale test done");
  endtask : t_scale
  task automatic t_sleep;
    go(7'h60);
    pulse(4'h4);
    in_ps = 1'b1;
    fire_at("sleep", 32);
    chk("wake", 16'({wd_wake, wd_rst, sl_flag}), 16'h5);
    in_ps = 1'b0;
    pulse(4'h2);
    chk("sleep kept", 16'(sl_flag), 16'h1);
    sl_clr = 1'b1;
    step(1);
    sl_clr = 1'b0;
    chk("sleep clear", 16'(sl_flag), 16'h0);
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_events;
    for (int k = 0; k < 4; k++)
    begin
      go(7'h60);
      step(200);
      pulse(4'(1 << k));
      fire_at("clear event", 32);
    end
    $display("event test done");
  endtask : t_events
  task automatic t_window;
    go(7'h42);
    step(100);
    pulse(4'h8);
    fire(10);
    chk("early clear", 16'({wd_rst, to_flag}), 16'h3);
    go(7'h42);
    step(950);
    pulse(4'h8);
    fire(300);
    chk("late clear", 16'(n), 16'd300);
    $display("window test done");
  endtask : t_window
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial
  begin
    t_soft();
    t_scale();
    t_sleep();
    t_events();
    t_window();
    wrap_up();
  end
  initial
  begin
    #1000000;
    num_errors++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
